// ===== hdl/retsub_exec_regs.svh
// constants for the literal-return and subtract execution block
`ifndef RETSUB_EXEC_REGS_SVH
`define RETSUB_EXEC_REGS_SVH
// opcode patterns (upper byte of the 16-bit word)
`define OPC_RET_LIT        8'h0c
`define OPC_LIT_SUB        8'h08
`define OPC_FILE_SUB_MASK  8'hfc
`define OPC_FILE_SUB       8'h5c
// field positions in the instruction word
`define FLD_DEST_BIT       9
`define FLD_BANK_BIT       8
// highest file address that uses indexed literal-offset addressing
`define IDX_OFFSET_LIMIT   8'h5f
// status flag bit positions
`define FLAG_C_BIT         0
`define FLAG_DC_BIT        1
`define FLAG_Z_BIT         2
`define FLAG_OV_BIT        3
`define FLAG_N_BIT         4
// reset values
`define WORK_RESET         8'h00
`define FLAGS_RESET        5'h00
`endif

// ===== hdl/retsub_exec_pkg.sv
// types for the literal-return and subtract execution block
package retsub_exec_pkg;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
  typedef enum logic [1:0] {ST_RUN, ST_NOP} cyc_t;
  // subtract unit result
  typedef struct packed {
    logic [7:0] diff;
    logic [4:0] flags;
  } sub_res_t;
  // data-memory write request
  typedef struct packed {
    logic       we;
    logic       indexed;
    logic       banked;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] data;
  } mem_wr_t;
endpackage : retsub_exec_pkg

// ===== hdl/byte_subtract.sv
// eight-bit subtractor with status flags
`timescale 1ns/10ps
`include "retsub_exec_regs.svh"
module byte_subtract
  import retsub_exec_pkg::*;
(
  // operands
  input  wire logic [7:0] minuend_i,
  input  wire logic [7:0] subtrahend_i,
  // result
  output sub_res_t        res_o
);
  logic [8:0] full;
  logic [4:0] low;
  // two's complement subtract, carry means no borrow
  always_comb begin
    full = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + 9'h001;
    low  = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + 5'h01;
    res_o.diff = full[7:0];
    res_o.flags = 5'h00;
    res_o.flags[`FLAG_C_BIT]  = full[8];
    res_o.flags[`FLAG_DC_BIT] = low[4];
    res_o.flags[`FLAG_Z_BIT]  = (full[7:0] == 8'h00);
    res_o.flags[`FLAG_N_BIT]  = full[7];
    res_o.flags[`FLAG_OV_BIT] = (minuend_i[7] != subtrahend_i[7]) && (full[7] != minuend_i[7]);
  end
endmodule : byte_subtract

// ===== hdl/retsub_exec.sv
// execution logic for return-with-literal and the two subtracts
// Summary of operation
// - return_with_literal loads the literal into work and pops stack_top into the pc, latches untouched.
// - return_with_literal is one word, two cycles, pop and work write in Q4 of the first, second is a nop.
// - literal_minus_work puts literal minus work into work in one cycle.
// - file_minus_work computes file register minus work by two's complement in one cycle.
// - a clear destination bit sends the result to work, a set one back to the file register.
// - a clear bank bit selects the shared bank, a set one uses bank_select_register.
// - bank bit clear, extended set on and address up to 5fh selects indexed literal-offset addressing.
`timescale 1ns/10ps
`include "retsub_exec_regs.svh"
module retsub_exec
  import retsub_exec_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // decoder side
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  input  wire logic        ext_set_en_i,
  // core state
  input  wire logic [3:0]  bank_select_register_i,
  input  wire logic [7:0]  file_data_i,
  input  wire logic [20:0] stack_top_i,
  // results
  output logic [7:0]       work_o,
  output logic [4:0]       flags_o,
  output logic [20:0]      pc_load_val_o,
  output logic             pc_load_o,
  output logic             stack_pop_o,
  output mem_wr_t          mem_wr_o,
  output logic             busy_o,
  output phase_t           phase_o
);
  // complete state of the block
  typedef struct packed {
    phase_t     phase;
    cyc_t       cyc;
    logic [15:0] ins;
    logic       held;
    logic [7:0] work;
    logic [4:0] flags;
    logic [20:0] pcv;
    logic       pcl;
    logic       pop;
    logic       busy;
    mem_wr_t    mw;
  } state_t;

  state_t s_r, s_nxt;
  sub_res_t sub_res;
  logic [7:0] minu;
  logic is_ret, is_lsub, is_fsub;

  // decode of the held instruction
  always_comb begin
    is_ret  = s_r.held && (s_r.cyc == ST_RUN) && (s_r.ins[15:8] == `OPC_RET_LIT);
    is_lsub = s_r.held && (s_r.ins[15:8] == `OPC_LIT_SUB);
    is_fsub = s_r.held && ((s_r.ins[15:8] & `OPC_FILE_SUB_MASK) == `OPC_FILE_SUB);
    minu    = is_fsub ? file_data_i : s_r.ins[7:0];
  end

  // shared subtractor
  byte_subtract u_sub (
    .minuend_i    (minu),
    .subtrahend_i (s_r.work),
    .res_o        (sub_res)
  );

  // -----------------------------
  // phase sequencing and execution
  // -----------------------------
  always_comb begin
    s_nxt     = s_r;
    s_nxt.pcl = 1'b0;
    s_nxt.pop = 1'b0;
    s_nxt.mw.we = 1'b0;
    case (s_r.phase)
      PH_Q1: begin
        s_nxt.phase = PH_Q2;
        if (s_r.cyc == ST_RUN) begin
          s_nxt.held = instr_valid_i;
          s_nxt.ins  = instr_i;
        end
      end
      PH_Q2: s_nxt.phase = PH_Q3;
      PH_Q3: begin
        s_nxt.phase = PH_Q4;
        if (is_ret) begin
          s_nxt.work = s_r.ins[7:0];
          s_nxt.pcv  = stack_top_i;
          s_nxt.pcl  = 1'b1;
          s_nxt.pop  = 1'b1;
        end else if (is_lsub) begin
          s_nxt.work  = sub_res.diff;
          s_nxt.flags = sub_res.flags;
        end else if (is_fsub) begin
          s_nxt.flags = sub_res.flags;
          if (!s_r.ins[`FLD_DEST_BIT]) begin
            s_nxt.work = sub_res.diff;
          end else begin
            s_nxt.mw.we   = 1'b1;
            s_nxt.mw.data = sub_res.diff;
          end
        end
      end
      PH_Q4: begin
        s_nxt.phase = PH_Q1;
        if (is_ret) begin
          s_nxt.cyc  = ST_NOP;
          s_nxt.busy = 1'b1;
        end else begin
          s_nxt.cyc  = ST_RUN;
          s_nxt.busy = 1'b0;
          s_nxt.held = (s_r.cyc == ST_NOP) ? 1'b0 : s_r.held;
        end
        if (s_r.cyc == ST_NOP) begin
          s_nxt.held = 1'b0;
        end
      end
      default: s_nxt.phase = PH_Q1;
    endcase
    // addressing of the file operand
    s_nxt.mw.addr    = s_r.ins[7:0];
    s_nxt.mw.banked  = s_r.ins[`FLD_BANK_BIT];
    s_nxt.mw.bank    = s_r.ins[`FLD_BANK_BIT] ? bank_select_register_i : 4'h0;
    s_nxt.mw.indexed = !s_r.ins[`FLD_BANK_BIT] && ext_set_en_i
                       && (s_r.ins[7:0] <= `IDX_OFFSET_LIMIT);
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_r <= '0;
      s_r.work  <= `WORK_RESET;
      s_r.flags <= `FLAGS_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  always_comb begin
    work_o        = s_r.work;
    flags_o       = s_r.flags;
    pc_load_val_o = s_r.pcv;
    pc_load_o     = s_r.pcl;
    stack_pop_o   = s_r.pop;
    mem_wr_o      = s_r.mw;
    busy_o        = s_r.busy;
    phase_o       = s_r.phase;
  end

  // -----------------------------
  // checks
  // -----------------------------
  property p_ret_work;
    @(posedge ref_clk_i) disable iff (reset_i)
      is_ret && s_r.phase == PH_Q3 |=> work_o == $past(s_r.ins[7:0]) && pc_load_o && stack_pop_o;
  endproperty
  a_ret_work: assert property (p_ret_work) else $error("literal return failed");

  property p_ret_nop;
    @(posedge ref_clk_i) disable iff (reset_i)
      is_ret && s_r.phase == PH_Q4 |=> busy_o [*4] ##1 !busy_o;
  endproperty
  a_ret_nop: assert property (p_ret_nop) else $error("second cycle not a nop");

  property p_nop_quiet;
    @(posedge ref_clk_i) disable iff (reset_i)
      busy_o |-> !mem_wr_o.we && !pc_load_o && !stack_pop_o && $stable(work_o) && $stable(flags_o);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("activity during nop");

  property p_lsub;
    @(posedge ref_clk_i) disable iff (reset_i)
      is_lsub && s_r.phase == PH_Q3 |=> work_o == $past(s_r.ins[7:0]) - $past(s_r.work);
  endproperty
  a_lsub: assert property (p_lsub) else $error("literal subtract wrong");

  property p_fsub_file;
    @(posedge ref_clk_i) disable iff (reset_i)
      is_fsub && s_r.phase == PH_Q3 && s_r.ins[`FLD_DEST_BIT]
      |=> mem_wr_o.we && mem_wr_o.data == $past(file_data_i) - $past(s_r.work);
  endproperty
  a_fsub_file: assert property (p_fsub_file) else $error("file destination wrong");

  property p_fsub_work;
    @(posedge ref_clk_i) disable iff (reset_i)
      is_fsub && s_r.phase == PH_Q3 && !s_r.ins[`FLD_DEST_BIT]
      |=> !mem_wr_o.we && work_o == $past(file_data_i) - $past(s_r.work);
  endproperty
  a_fsub_work: assert property (p_fsub_work) else $error("work destination wrong");

  property p_bank;
    @(posedge ref_clk_i) disable iff (reset_i)
      $past(s_r.ins[`FLD_BANK_BIT]) == 1'b0 |-> mem_wr_o.bank == 4'h0 && !mem_wr_o.banked;
  endproperty
  a_bank: assert property (p_bank) else $error("shared bank not selected");

  property p_index;
    @(posedge ref_clk_i) disable iff (reset_i)
      mem_wr_o.indexed |-> !mem_wr_o.banked && mem_wr_o.addr <= `IDX_OFFSET_LIMIT;
  endproperty
  a_index: assert property (p_index) else $error("indexed mode misused");

  property p_flags;
    @(posedge ref_clk_i) disable iff (reset_i)
      (is_lsub || is_fsub) && s_r.phase == PH_Q3
      |=> flags_o[`FLAG_Z_BIT] == ($past(sub_res.diff) == 8'h00)
          && flags_o[`FLAG_C_BIT] == ($past(minu) >= $past(s_r.work));
  endproperty
  a_flags: assert property (p_flags) else $error("subtract flags wrong");

  property p_ret_pc;
    @(posedge ref_clk_i) disable iff (reset_i)
      is_ret && s_r.phase == PH_Q3 |=> pc_load_val_o == $past(stack_top_i) && $stable(flags_o);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return address or flags wrong");

  property p_pulse;
    @(posedge ref_clk_i) disable iff (reset_i)
      pc_load_o || stack_pop_o || mem_wr_o.we |=> !pc_load_o && !stack_pop_o && !mem_wr_o.we;
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
endmodule : retsub_exec

// ===== tb/retsub_exec_tb.sv
// self-checking bench for the literal-return and subtract block
`timescale 1ns/10ps
`include "retsub_exec_regs.svh"
module retsub_exec_tb
  import retsub_exec_pkg::*;
;
  // ------------------------------
  // signals and design
  // ------------------------------
  logic        ref_clk_i              = 1'b0;
  logic        reset_i                = 1'b1;
  logic        instr_valid_i          = 1'b0;
  logic [15:0] instr_i                = 16'h0000;
  logic        ext_set_en_i           = 1'b0;
  logic [3:0]  bank_select_register_i = 4'h0;
  logic [7:0]  file_data_i            = 8'h00;
  logic [20:0] stack_top_i            = 21'h00000;
  logic [7:0]  work_o;
  logic [4:0]  flags_o;
  logic [20:0] pc_load_val_o;
  logic        pc_load_o;
  logic        stack_pop_o;
  logic        busy_o;
  mem_wr_t     mem_wr_o;
  phase_t      phase_o;
  logic [7:0]  wk = 8'h00;
  int          n_fail = 0;
  int          compares = 0;

  retsub_exec retsub_exec_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .ext_set_en_i(ext_set_en_i), .bank_select_register_i(bank_select_register_i),
    .file_data_i(file_data_i), .stack_top_i(stack_top_i), .work_o(work_o), .flags_o(flags_o),
    .pc_load_val_o(pc_load_val_o), .pc_load_o(pc_load_o), .stack_pop_o(stack_pop_o),
    .mem_wr_o(mem_wr_o), .busy_o(busy_o), .phase_o(phase_o));

  // free-running clock
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk_val(input string name, input logic [20:0] exp, input logic [20:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  // flags laid out as n, ov, z, dc, c
  function automatic logic [4:0] exp_flags(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    return {d[7], (a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b};
  endfunction : exp_flags

  // wait for q4, offer the word for the next q1 edge, return in q4 of that cycle
  task automatic issue(input logic [15:0] w, input logic [7:0] fd, input logic [20:0] top);
    int n;
    n = 0;
    while (phase_o !== PH_Q4 && n < 16) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (phase_o !== PH_Q4) begin
      n_fail++;
    end
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= w;
    file_data_i   <= fd;
    stack_top_i   <= top;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : issue

  task automatic end_sim();
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // ------------------------------
  // scenarios
  // ------------------------------
  // return with literal, then a word offered in the nop cycle is ignored
  task automatic ret_lit(input logic [7:0] k, input logic [20:0] top);
    issue({`OPC_RET_LIT, k}, 8'h00, top);
    wk = k;
    chk_val("work", 21'(wk), 21'(work_o));
    chk_val("pc value", top, pc_load_val_o);
    chk_val("pc load", 21'h1, 21'(pc_load_o));
    chk_val("pop", 21'h1, 21'(stack_pop_o));
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= {`OPC_LIT_SUB, 8'h00};
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk_val("busy nop", 21'h1, 21'(busy_o));
    chk_val("pop nop", 21'h0, 21'(stack_pop_o));
    chk_val("work nop", 21'(wk), 21'(work_o));
  endtask : ret_lit

  task automatic lit_sub(input logic [7:0] k);
    issue({`OPC_LIT_SUB, k}, 8'h00, 21'h00000);
    chk_val("flags", 21'(exp_flags(k, wk)), 21'(flags_o));
    wk = k - wk;
    chk_val("work", 21'(wk), 21'(work_o));
    chk_val("busy", 21'h0, 21'(busy_o));
    chk_val("pop", 21'h0, 21'(stack_pop_o));
    chk_val("pc load", 21'h0, 21'(pc_load_o));
  endtask : lit_sub

  task automatic file_sub(input logic d, input logic a, input logic ext, input logic [3:0] bank_select_register,
                          input logic [7:0] f, input logic [7:0] fd);
    logic [7:0] diff;
    diff = fd - wk;
    @(posedge ref_clk_i);
    ext_set_en_i           <= ext;
    bank_select_register_i <= bank_select_register;
    @(negedge ref_clk_i);
    issue({6'b010111, d, a, f}, fd, 21'h00000);
    chk_val("flags", 21'(exp_flags(fd, wk)), 21'(flags_o));
    if (d == 1'b0) begin
      wk = diff;
    end
    chk_val("work", 21'(wk), 21'(work_o));
    chk_val("write", 21'(d), 21'(mem_wr_o.we));
    if (d) begin
      chk_val("data", 21'(diff), 21'(mem_wr_o.data));
    end
    chk_val("addr", 21'(f), 21'(mem_wr_o.addr));
    chk_val("banked", 21'(a), 21'(mem_wr_o.banked));
    chk_val("bank", 21'(a ? bank_select_register : 4'h0), 21'(mem_wr_o.bank));
    chk_val("indexed", 21'(!a && ext && (f <= 8'h5f)), 21'(mem_wr_o.indexed));
  endtask : file_sub

  // main sequence
  initial begin
    logic [7:0] wt [4];
    logic [7:0] kt [4];
    wt = '{8'h01, 8'h02, 8'h03, 8'h01};
    kt = '{8'h02, 8'h02, 8'h02, 8'h80};
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(negedge ref_clk_i);
    chk_val("work reset", 21'(`WORK_RESET), 21'(work_o));
    chk_val("flags reset", 21'(`FLAGS_RESET), 21'(flags_o));
    chk_val("phase reset", 21'(PH_Q1), 21'(phase_o));
    chk_val("busy reset", 21'h0, 21'(busy_o));
    for (int i = 0; i < 4; i++) begin
      ret_lit(wt[i], 21'h1abcd0 + 21'(i));
      lit_sub(kt[i]);
    end
    lit_sub(8'h00);
    file_sub(1'b1, 1'b0, 1'b0, 4'h5, 8'h20, 8'h03);
    file_sub(1'b0, 1'b1, 1'b1, 4'ha, 8'h40, 8'h02);
    file_sub(1'b1, 1'b0, 1'b1, 4'h3, 8'h5f, 8'h01);
    file_sub(1'b0, 1'b0, 1'b1, 4'h3, 8'h60, 8'h90);
    file_sub(1'b1, 1'b1, 1'b1, 4'hf, 8'h10, 8'h7f);
    end_sim();
  end

  // watchdog
  initial begin
    #40000;
    n_fail++;
    end_sim();
  end
endmodule : retsub_exec_tb
